// ==== verilog/tmoc_top.sv ====
`timescale 1ns/1ps
`include "tmoc_params.svh"

module tmoc_top #(
   parameter int CHANNELS = 3
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // Counter unit
   input  wire logic                   timer_tick,
   input  wire logic [`TMOC_CW-1:0]    counter_value,
   input  wire logic                   counter_wr,
   input  wire logic                   at_top,
   input  wire logic                   at_count_lower_limit,
   input  wire logic                   count_up,
   // Interrupt handshake
   input  wire logic [2:0]             irq_ack,
   output logic      [2:0]             irq_req,
   // Port pins
   input  wire logic [2:0]             port_out,
   input  wire logic [2:0]             output_pin_direction_bit,
   output logic      [2:0]             pin_o,
   output logic      [2:0]             pin_oe_n,
   // Observation
   output logic      [2:0]             match_o,
   output logic      [2:0]             compare_output_state,
   output logic      [`TMOC_CW-1:0]    limit_value
);

   localparam int CW = `TMOC_CW;

   // Elaboration check
   if (CHANNELS != 3)
   begin : g_chk
      $error("tmoc_top serves exactly three channels");
   end

   // Mode family of the waveform mode bits
   function automatic tmoc_pkg::tmoc_class_e mode_class(input logic [3:0] m);
      unique case (m)
         4'd0, 4'd4, 4'd12:             mode_class = tmoc_pkg::TMOC_NONPWM;
         4'd5, 4'd6, 4'd7, 4'd14, 4'd15: mode_class = tmoc_pkg::TMOC_FAST;
         4'd13:                         mode_class = tmoc_pkg::TMOC_RESV;
         default:                       mode_class = tmoc_pkg::TMOC_PHASE;
      endcase
   endfunction

   // Output state after a match or force
   function automatic logic on_match(input logic [3:0] m, input logic [1:0] a,
                                     input logic is_a, input logic up,
                                     input logic cur);
      on_match = cur;
      unique case (mode_class(m))
         tmoc_pkg::TMOC_NONPWM:
         begin
            unique case (a)
               2'd1:    on_match = ~cur;
               2'd2:    on_match = 1'b0;
               2'd3:    on_match = 1'b1;
               default: on_match = cur;
            endcase
         end
         tmoc_pkg::TMOC_FAST:
         begin
            if (a == 2'd1 && is_a && m == 4'd15)
               on_match = ~cur;
            else if (a[1])
               on_match = a[0];
         end
         tmoc_pkg::TMOC_PHASE:
         begin
            if (a == 2'd1 && is_a && m[0])
               on_match = ~cur;
            else if (a[1])
               on_match = a[0] ~^ ~up;
         end
         tmoc_pkg::TMOC_RESV: on_match = cur;
      endcase
   endfunction

   // Register state
   tmoc_pkg::tmoc_ctrl_s   ctrl_reg, ctrl_next;
   tmoc_pkg::tmoc_aphase_s ap_reg, ap_next;
   logic                   wph_reg, wph_next;
   logic [31:0]            rd_reg, rd_next;
   logic [7:0]             temp_reg, temp_next;
   logic [CW-1:0]          act_reg [3];
   logic [CW-1:0]          act_next [3];
   logic [CW-1:0]          buf_reg [3];
   logic [CW-1:0]          buf_next [3];
   logic [2:0]             flag_reg, flag_next;
   logic [2:0]             pend_reg, pend_next;
   logic [2:0]             oc_reg, oc_next;
   logic                   block_reg, block_next;

   // Decode helpers
   tmoc_pkg::tmoc_class_e  cls;
   logic                   pwm;
   logic                   upd_now;
   logic                   ap_take;
   logic [7:0]             wbyte;

   // Mode-derived controls and buffer transfer point
   always_comb
   begin
      cls     = mode_class(ctrl_reg.mode);
      pwm     = (cls == tmoc_pkg::TMOC_FAST) || (cls == tmoc_pkg::TMOC_PHASE);
      // Phase and frequency correct modes update at the lower limit
      if (ctrl_reg.mode == 4'd8 || ctrl_reg.mode == 4'd9)
         upd_now = timer_tick & at_count_lower_limit;
      else
         upd_now = timer_tick & at_top;
      ap_take = hsel & htrans[1] & hready;
      wbyte   = hwdata[7:0];
   end

   // Continuous equality of counter and active values
   always_comb
   begin
      for (int c = 0; c < 3; c++)
         match_o[c] = (act_reg[c] == counter_value);
   end

   // Bus, compare values, flags and output state
   always_comb
   begin
      logic [7:0] off;
      logic       wr;
      off        = ap_reg.addr;
      wr         = wph_reg;
      ctrl_next  = ctrl_reg;
      temp_next  = temp_reg;
      flag_next  = flag_reg;
      oc_next    = oc_reg;
      ap_next    = ap_reg;
      wph_next   = 1'b0;
      rd_next    = rd_reg;
      for (int c = 0; c < 3; c++)
      begin
         act_next[c] = act_reg[c];
         buf_next[c] = buf_reg[c];
      end

      // Counter write blocks the next timer clock's matches
      block_next = counter_wr | (block_reg & ~timer_tick);
      pend_next  = pend_reg;
      if (timer_tick)
         pend_next = match_o & {3{~block_reg}};

      // Buffered value reaches the comparator at the limit
      if (pwm && upd_now)
      begin
         for (int c = 0; c < 3; c++)
            act_next[c] = buf_reg[c];
      end

      // Match events one timer clock after equality
      for (int c = 0; c < 3; c++)
      begin
         if (timer_tick && pend_reg[c])
         begin
            oc_next[c] = on_match(ctrl_reg.mode, ctrl_reg.action[c], c == 0,
                                  count_up, oc_reg[c]);
         end
         else if (timer_tick && at_count_lower_limit && cls == tmoc_pkg::TMOC_FAST
                  && ctrl_reg.action[c][1])
         begin
            oc_next[c] = ~ctrl_reg.action[c][0];
         end
      end

      // Interrupt service clears the flag
      flag_next = flag_next & ~irq_ack;

      // Register writes in the data phase
      if (wr)
      begin
         unique case (off)
            `TMOC_OFF_CTRL:
               ctrl_next = hwdata[12:0];
            `TMOC_OFF_FLAGS:
               flag_next = flag_next & ~hwdata[2:0];
            `TMOC_OFF_FORCE:
            begin
               if (cls == tmoc_pkg::TMOC_NONPWM)
               begin
                  for (int c = 0; c < 3; c++)
                     if (hwdata[c])
                        oc_next[c] = on_match(ctrl_reg.mode, ctrl_reg.action[c],
                                              c == 0, count_up, oc_reg[c]);
               end
            end
            default:
            begin
               for (int c = 0; c < 3; c++)
               begin
                  if (off == `TMOC_OFF_CMP_HIGH + 8'(c) * `TMOC_CMP_STRIDE)
                     temp_next = wbyte;
                  if (off == `TMOC_OFF_CMP_LOW + 8'(c) * `TMOC_CMP_STRIDE)
                  begin
                     if (pwm)
                        buf_next[c] = {temp_reg, wbyte};
                     else
                        act_next[c] = {temp_reg, wbyte};
                  end
               end
            end
         endcase
      end

      // Hardware set wins over any clear in the same cycle
      for (int c = 0; c < 3; c++)
         if (timer_tick && pend_reg[c])
            flag_next[c] = 1'b1;

      // Address phase capture and registered read data
      if (ap_take)
      begin
         ap_next.addr = haddr[7:0];
         ap_next.wr   = hwrite;
         wph_next     = hwrite;
         rd_next      = 32'h0000_0000;
         if (!hwrite)
         begin
            unique case (haddr[7:0])
               `TMOC_OFF_CTRL:   rd_next = {19'h0_0000, ctrl_reg};
               `TMOC_OFF_FLAGS:  rd_next = {29'h0000_0000, flag_reg};
               `TMOC_OFF_STATUS: rd_next = {26'h000_0000, match_o, oc_reg};
               default:
               begin
                  for (int c = 0; c < 3; c++)
                  begin
                     if (haddr[7:0] == `TMOC_OFF_CMP_LOW + 8'(c) * `TMOC_CMP_STRIDE)
                        rd_next = {24'h00_0000,
                                   pwm ? buf_reg[c][7:0] : act_reg[c][7:0]};
                     if (haddr[7:0] == `TMOC_OFF_CMP_HIGH + 8'(c) * `TMOC_CMP_STRIDE)
                        rd_next = {24'h00_0000,
                                   pwm ? buf_reg[c][15:8] : act_reg[c][15:8]};
                  end
               end
            endcase
         end
      end
   end

   // State registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_reg  <= `TMOC_CTRL_RESET;
         ap_reg    <= '0;
         wph_reg   <= 1'b0;
         rd_reg    <= 32'h0000_0000;
         temp_reg  <= 8'h00;
         flag_reg  <= 3'h0;
         pend_reg  <= 3'h0;
         oc_reg    <= 3'h0;
         block_reg <= 1'b0;
         for (int c = 0; c < 3; c++)
         begin
            act_reg[c] <= `TMOC_CMP_RESET;
            buf_reg[c] <= `TMOC_CMP_RESET;
         end
      end
      else
      begin
         ctrl_reg  <= ctrl_next;
         ap_reg    <= ap_next;
         wph_reg   <= wph_next;
         rd_reg    <= rd_next;
         temp_reg  <= temp_next;
         flag_reg  <= flag_next;
         pend_reg  <= pend_next;
         oc_reg    <= oc_next;
         block_reg <= block_next;
         for (int c = 0; c < 3; c++)
         begin
            act_reg[c] <= act_next[c];
            buf_reg[c] <= buf_next[c];
         end
      end
   end

   // Bus answer: zero wait, always OKAY
   assign hrdata    = rd_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Interrupt requests of all three channels; limit from channel A
   assign irq_req     = flag_reg & ctrl_reg.irq_en;
   assign limit_value = act_reg[0];

   // Pin override; only the waveform path sees the action bits
   always_comb
   begin
      compare_output_state = oc_reg;
      for (int c = 0; c < 3; c++)
      begin
         pin_o[c]    = (|ctrl_reg.action[c]) ? oc_reg[c] : port_out[c];
         pin_oe_n[c] = ~output_pin_direction_bit[c];
      end
   end

endmodule

// ==== verilog/tmoc_params.svh ====
// Behaviour
// - Compare full 16-bit counter with each active compare value; flag equality as match.
// - Match flag sets one timer clock after equality, not in the same cycle.
// - Enabled flag requests interrupt; servicing the interrupt clears the flag.
// - Writing one to a flag bit clears it; zero leaves it.
// - Channel A compare value serves as counter upper limit and waveform period.
// - Compare value double-buffered in all twelve PWM modes; direct otherwise.
// - Buffered value moves to active value only at upper or lower limit.
// - CPU compare accesses reach buffer when buffering, active value when not.
// - Compare reads return bytes directly, no shared latch; low byte first advised.
// - High byte goes to shared latch; low write loads latch into upper byte.
// - Force strobe in non-PWM modes acts like a match; no flag, no counter change.
// - Counter write blocks all matches in the next timer clock, even when stopped.
// - Compare output state keeps its value across waveform mode changes.
// - Output action bit writes take effect immediately.
// - Output action and mode bits decide output state change at next match.
// - Reset clears every compare output state to zero.
// - Nonzero output action bits put compare output state on pin; direction unchanged.
// - Output action bits do not affect input capture.
// - Output action zero leaves output state unchanged on a match, every mode.
// - In clear-on-match mode, output action one toggles state on each match.
`ifndef TMOC_PARAMS_SVH
`define TMOC_PARAMS_SVH

`define TMOC_CW              16
`define TMOC_OFF_CTRL        8'h00
`define TMOC_OFF_FLAGS       8'h04
`define TMOC_OFF_FORCE       8'h08
`define TMOC_OFF_STATUS      8'h0C
`define TMOC_OFF_CMP_LOW     8'h10
`define TMOC_OFF_CMP_HIGH    8'h14
`define TMOC_CMP_STRIDE      8'h08
`define TMOC_CTRL_MODE_LSB   0
`define TMOC_CTRL_ACT_LSB    4
`define TMOC_CTRL_IEN_LSB    10
`define TMOC_STAT_MATCH_LSB  3
`define TMOC_CTRL_RESET      13'h0000
`define TMOC_CMP_RESET       16'h0000

`endif

// ==== verilog/tmoc_pkg.sv ====
package tmoc_pkg;

   // Waveform mode families, Gray coded
   typedef enum logic [1:0] {
      TMOC_NONPWM = 2'b00,
      TMOC_FAST   = 2'b01,
      TMOC_PHASE  = 2'b11,
      TMOC_RESV   = 2'b10
   } tmoc_class_e;

   // Software control word
   typedef struct packed {
      logic [2:0]       irq_en;
      logic [2:0][1:0]  action;
      logic [3:0]       mode;
   } tmoc_ctrl_s;

   // Captured AHB address phase
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
   } tmoc_aphase_s;

endpackage

// ==== dv/tmoc_pin_model.sv ====
`timescale 1ns/1ps

// Far-side pad: driven level, else inverse of the last driven level
module tmoc_pin_model (
   // Pad side
   input  wire logic       clk,
   input  wire logic [2:0] pin_o,
   input  wire logic [2:0] pin_oe_n,
   output logic      [2:0] pad
);
   logic [2:0] last_reg;

   // Remember each driven level
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 3; i++)
         if (!pin_oe_n[i]) last_reg[i] <= pin_o[i];
   end

   // Released pins float away from the old level
   assign pad = (pin_o & ~pin_oe_n) | (~last_reg & pin_oe_n);
endmodule

// ==== dv/tmoc_asserts.sv ====
`timescale 1ns/1ps
`include "tmoc_params.svh"

module tmoc_asserts #(
   parameter int CHANNELS = 3
) (
   // Clock and reset
   input wire logic                clk,
   input wire logic                reset,
   // Register bus
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic [31:0]         hwdata,
   input wire logic                hready,
   input wire logic [31:0]         hrdata,
   // Timer, interrupts and pins
   input wire logic                timer_tick,
   input wire logic [`TMOC_CW-1:0] counter_value,
   input wire logic [2:0]          irq_ack,
   input wire logic [2:0]          irq_req,
   input wire logic [2:0]          port_out,
   input wire logic [2:0]          output_pin_direction_bit,
   input wire logic [2:0]          pin_o,
   input wire logic [2:0]          pin_oe_n,
   input wire logic [2:0]          match_o,
   input wire logic [2:0]          compare_output_state,
   input wire logic [`TMOC_CW-1:0] limit_value
);
   logic        acc;
   logic        wp_reg;
   logic [7:0]  wa_reg;
   logic [12:0] ctl_reg;
   logic [2:0]  ovr;

   // Accepted address phase and mirrored control word
   assign acc = hsel && htrans[1] && hready;
   assign ovr = {|ctl_reg[9:8], |ctl_reg[7:6], |ctl_reg[5:4]};
   always_ff @(posedge clk)
   begin
      if (acc) wa_reg <= haddr[7:0];
      if (reset)
      begin
         wp_reg  <= 1'b0;
         ctl_reg <= 13'h0000;
      end
      else
      begin
         wp_reg <= acc && hwrite;
         if (wp_reg && wa_reg == `TMOC_OFF_CTRL) ctl_reg <= hwdata[12:0];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_match_eq: assert property (match_o[0] == (counter_value == limit_value))
      else $error("match A disagrees with compare");
   a_reset_clear: assert property (disable iff (1'b0) reset |=>
      compare_output_state == 3'b000 && irq_req == 3'b000) else $error("reset left state");
   a_irq_ack: assert property (!timer_tick |=> (irq_req & $past(irq_ack)) == 3'b000)
      else $error("serviced request stays");
   a_irq_gate: assert property ((irq_req & ~ctl_reg[12:10]) == 3'b000)
      else $error("request while disabled");
   a_limit_sync: assert property ($changed(limit_value) |->
      $past(timer_tick) || $past(wp_reg) || $past(reset)) else $error("limit moved alone");
   a_state_cause: assert property ($changed(compare_output_state) |->
      $past(timer_tick) || $past(wp_reg) || $past(reset)) else $error("state moved alone");
   a_pin_mux: assert property (pin_o == ((compare_output_state & ovr) | (port_out & ~ovr)))
      else $error("pin source wrong");
   a_pin_dir: assert property (pin_oe_n == ~output_pin_direction_bit)
      else $error("pin direction wrong");
   a_rd_hold: assert property (!$past(acc) && !$past(reset) |-> $stable(hrdata))
      else $error("read data moved");
endmodule

bind tmoc_top tmoc_asserts #(.CHANNELS(CHANNELS)) i_tmoc_asserts (.clk, .reset, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .timer_tick, .counter_value,
   .irq_ack, .irq_req, .port_out, .output_pin_direction_bit, .pin_o, .pin_oe_n,
   .match_o, .compare_output_state, .limit_value);

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`include "tmoc_params.svh"

module tb;
   logic        clk, reset, hsel, hwrite, hreadyout, hresp, tick, cwr, top;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0]  htrans;
   logic [2:0]  ack, req, pout, dir, pin_o, oe_n, match_o, state, pad;
   logic [15:0] cnt, limit;
   int          n_fail, comparisons;

   // Device under test and pad model
   tmoc_top i_tmoc_top (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timer_tick(tick), .counter_value(cnt), .counter_wr(cwr), .at_top(top),
      .at_count_lower_limit(1'b0), .count_up(1'b1), .irq_ack(ack), .irq_req(req),
      .port_out(pout), .output_pin_direction_bit(dir), .pin_o(pin_o),
      .pin_oe_n(oe_n), .match_o(match_o), .compare_output_state(state),
      .limit_value(limit));
   tmoc_pin_model i_tmoc_pin_model (.clk(clk), .pin_o(pin_o), .pin_oe_n(oe_n), .pad(pad));

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic give_verdict();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // One single AHB transfer
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      haddr  <= {24'h0000_00, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      r = hrdata;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(r, e);
   endtask

   // One timer tick with counter value and upper-limit level
   task automatic tk(input logic [15:0] c, input logic t);
      @(posedge clk);
      tick <= 1'b1;
      cnt  <= c;
      top  <= t;
      @(posedge clk);
      tick <= 1'b0;
   endtask

   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict();
   end

   initial
   begin
      reset = 1'b1; hsel = 1'b1; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hwdata = '0;
      tick = 1'b0; cwr = 1'b0; cnt = 16'h0001; top = 1'b0; ack = 3'b000;
      pout = 3'b000; dir = 3'b000; n_fail = 0; comparisons = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rd(`TMOC_OFF_STATUS, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000);
      // Direct compare write, high byte first
      xfer(1'b1, `TMOC_OFF_CMP_HIGH, 32'h0000_0012);
      xfer(1'b1, `TMOC_OFF_CMP_LOW, 32'h0000_0034);
      #1 chk({16'h0000, limit}, 32'h0000_1234);
      rd(`TMOC_OFF_CMP_HIGH, 32'h0000_0012);
      rd(`TMOC_OFF_CMP_LOW, 32'h0000_0034);
      // Clear-on-match, toggle, irq A; flag one tick late, W1C, ack
      xfer(1'b1, `TMOC_OFF_CTRL, 32'h0000_0414);
      tk(16'h1234, 1'b0);
      #1 chk({29'h0, req}, 32'h0000_0000);
      tk(16'h0001, 1'b0);
      #1 chk({26'h0, req, state}, 32'h0000_0009);
      xfer(1'b1, `TMOC_OFF_FLAGS, 32'h0000_0000);
      rd(`TMOC_OFF_FLAGS, 32'h0000_0001);
      xfer(1'b1, `TMOC_OFF_FLAGS, 32'h0000_0001);
      rd(`TMOC_OFF_FLAGS, 32'h0000_0000);
      tk(16'h1234, 1'b0);
      tk(16'h0001, 1'b0);
      #1 chk({26'h0, req, state}, 32'h0000_0008);
      @(posedge clk) ack <= 3'b001;
      @(posedge clk) ack <= 3'b000;
      #1 chk({29'h0, req}, 32'h0000_0000);
      // Counter write blocks the next tick's match, timer stopped meanwhile
      @(posedge clk) cwr <= 1'b1; // never at lower limit, never counting down
      @(posedge clk) cwr <= 1'b0;
      repeat (4) @(posedge clk);
      tk(16'h1234, 1'b0);
      tk(16'h0001, 1'b0);
      rd(`TMOC_OFF_FLAGS, 32'h0000_0000);
      // Force toggles state without a flag
      xfer(1'b1, `TMOC_OFF_FORCE, 32'h0000_0001); // state set before pin output
      @(posedge clk) dir <= 3'b111;
      rd(`TMOC_OFF_STATUS, 32'h0000_0001);
      rd(`TMOC_OFF_FLAGS, 32'h0000_0000);
      // Action zero keeps state on a match
      xfer(1'b1, `TMOC_OFF_CTRL, 32'h0000_0004);
      tk(16'h1234, 1'b0);
      tk(16'h0001, 1'b0);
      rd(`TMOC_OFF_STATUS, 32'h0000_0001);
      #1 chk({29'h0, pad}, 32'h0000_0000);
      xfer(1'b1, `TMOC_OFF_CTRL, 32'h0000_0024);
      #1 chk({29'h0, pad}, 32'h0000_0001);
      // Fast PWM with limit A: buffered until the upper limit
      xfer(1'b1, `TMOC_OFF_CTRL, 32'h0000_002F);
      rd(`TMOC_OFF_STATUS, 32'h0000_0001);
      xfer(1'b1, `TMOC_OFF_CMP_HIGH, 32'h0000_0001);
      xfer(1'b1, `TMOC_OFF_CMP_LOW, 32'h0000_0000);
      rd(`TMOC_OFF_CMP_HIGH, 32'h0000_0001);
      tk(16'h0001, 1'b0);
      #1 chk({16'h0000, limit}, 32'h0000_1234);
      tk(16'h0001, 1'b1);
      #1 chk({16'h0000, limit}, 32'h0000_0100);
      @(posedge clk) dir <= 3'b000;
      #1 chk({29'h0, oe_n}, 32'h0000_0007);
      give_verdict();
   end
endmodule
